// *** logic/chop_meter_ctrl.sv ***
// What this block does
// - Drive, blanking and sample timing runs at 925 Hz chop
// - Double-rate tick plus complementary chop squares
// - Double-rate tick fires 180 us blanking one-shot
// - Blanking holds 180 us per chopper change
// - Tick also starts detector sample delay timer
// - Delay end fires one sample pulse per half
// - Pulse steered to current half's sample switch
// - Sample switches alternate, never both closed
// - Chop squares delayed, registered into chopper drives
// - Drives opposite; drive A longer and leads
// - First attenuator: pass or divide-by-100, exclusive
// - Second attenuator adds divide-by-10, three exclusive
// - Range decodes to attenuator switch pattern
// - Range 1 adds series filter resistance
// - Comparator input selects detector or Zener
// - Comparator result readable by controller
`timescale 1ns/1ps
`default_nettype none
module chop_meter_ctrl
    import chop_pkg::*;
#(
    parameter int HALF_CYC   = HALF_CHOP_CYC,
    parameter int BLANK_LEN  = BLANK_CYC,
    parameter int SAMPLE_DLY = SAMPLE_DLY_CYC,
    parameter int SAMPLE_LEN = SAMPLE_LEN_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              comparator_result_input_i,
    output logic                   chopper_drive_a_o,
    output logic                   chopper_drive_b_o,
    output logic                   blanking_hold_switch_o,
    output logic                   detector_sample_switch_a_o,
    output logic                   detector_sample_switch_b_o,
    output logic                   sample_filter_switch_o,
    output logic                   first_atten_pass_switch_o,
    output logic                   first_atten_div100_switch_o,
    output logic                   second_atten_pass_switch_o,
    output logic                   second_atten_div10_switch_o,
    output logic                   second_atten_div100_switch_o,
    output logic                   comparator_zener_select_o,
    output logic      [CODE_W-1:0] dac_code_o
);
    logic [TIMER_W-1:0] osc_cnt_reg;
    logic               tick_reg;
    logic               phase_reg;
    logic               phase_n_reg;
    logic [TIMER_W-1:0] edge_cnt_reg;
    logic               delay_active;
    logic               delay_done;
    logic               sample_active;
    logic [2:0]         range_reg;
    logic               start_reg;
    logic               wb_req;

    sar_if #(.CODE_W(CODE_W)) sar ();

    // Master oscillator: tick at twice the chop rate
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            osc_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end else if (osc_cnt_reg == TIMER_W'(HALF_CYC - 1)) begin
            osc_cnt_reg <= '0;
            tick_reg    <= 1'b1;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 1'b1;
            tick_reg    <= 1'b0;
        end
    end

    // Complementary chop-rate squares
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_reg   <= 1'b0;
            phase_n_reg <= 1'b1;
        end else if (tick_reg) begin
            phase_reg   <= ~phase_reg;
            phase_n_reg <= phase_reg;
        end
    end

    // Cycles since the last chop edge, saturating
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            edge_cnt_reg <= '0;
        end else if (tick_reg) begin
            edge_cnt_reg <= '0;
        end else if (edge_cnt_reg != '1) begin
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
    end

    // Delayed, registered chopper drives; A leads and is longer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            chopper_drive_a_o <= 1'b0;
            chopper_drive_b_o <= 1'b0;
        end else begin
            if (phase_reg) begin
                chopper_drive_a_o <= (edge_cnt_reg >= TIMER_W'(DRV_LEAD_CYC));
                chopper_drive_b_o <= (edge_cnt_reg < TIMER_W'(DRV_LAG_CYC)) && chopper_drive_b_o;
            end else begin
                chopper_drive_a_o <= (edge_cnt_reg < TIMER_W'(DRV_LAG_CYC)) && chopper_drive_a_o;
                chopper_drive_b_o <= phase_n_reg && (edge_cnt_reg >= TIMER_W'(DRV_LAG_CYC));
            end
        end
    end

    // Spike blanking hold after every chop edge
    pulse_timer #(
        .CW    (TIMER_W),
        .COUNT (BLANK_LEN)
    ) u_blank (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .trig_i    (tick_reg),
        .active_o  (blanking_hold_switch_o),
        .done_o    ()
    );

    // Delay before the detector sample
    pulse_timer #(
        .CW    (TIMER_W),
        .COUNT (SAMPLE_DLY)
    ) u_sdelay (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .trig_i    (tick_reg),
        .active_o  (delay_active),
        .done_o    (delay_done)
    );

    // Sample pulse once per half cycle
    pulse_timer #(
        .CW    (TIMER_W),
        .COUNT (SAMPLE_LEN)
    ) u_sample (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .trig_i    (delay_done),
        .active_o  (sample_active),
        .done_o    ()
    );

    // Steer the sample pulse to the switch of the current half
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            detector_sample_switch_a_o <= 1'b0;
            detector_sample_switch_b_o <= 1'b0;
        end else begin
            detector_sample_switch_a_o <= sample_active && !delay_active && !tick_reg && phase_reg;
            detector_sample_switch_b_o <= sample_active && !delay_active && !tick_reg && !phase_reg;
        end
    end

    // Range decode to attenuator switches
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            first_atten_pass_switch_o    <= 1'b0;
            first_atten_div100_switch_o  <= 1'b1;
            second_atten_pass_switch_o   <= 1'b0;
            second_atten_div10_switch_o  <= 1'b0;
            second_atten_div100_switch_o <= 1'b1;
            sample_filter_switch_o       <= 1'b0;
        end else begin
            first_atten_pass_switch_o    <= (range_reg == RANGE_1) || (range_reg == RANGE_2);
            first_atten_div100_switch_o  <= !((range_reg == RANGE_1) || (range_reg == RANGE_2));
            second_atten_pass_switch_o   <= (range_reg == RANGE_1) || (range_reg == RANGE_3);
            second_atten_div10_switch_o  <= (range_reg == RANGE_2) || (range_reg == RANGE_4);
            second_atten_div100_switch_o <= !((range_reg == RANGE_1) || (range_reg == RANGE_2)
                                             || (range_reg == RANGE_3) || (range_reg == RANGE_4));
            sample_filter_switch_o       <= (range_reg == RANGE_1);
        end
    end

    // Wishbone slave: one wait state, then ack for one cycle
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Control register writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            range_reg                 <= RANGE_RST;
            comparator_zener_select_o <= 1'b0;
            start_reg                 <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (wb_req && wb_we_i && (wb_adr_i == CTRL_OFS)) begin
                if (wb_sel_i[0]) begin
                    range_reg                 <= wb_dat_i[RANGE_LSB +: RANGE_W];
                    comparator_zener_select_o <= wb_dat_i[ZSEL_BIT];
                end
                if (wb_sel_i[1] && wb_dat_i[START_BIT] && !sar.busy) begin
                    start_reg <= 1'b1;
                end
            end
        end
    end

    // Register reads
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFS: begin
                    wb_dat_o                          <= '0;
                    wb_dat_o[RANGE_LSB +: RANGE_W]    <= range_reg;
                    wb_dat_o[ZSEL_BIT]                <= comparator_zener_select_o;
                end
                STATUS_OFS: begin
                    wb_dat_o           <= '0;
                    wb_dat_o[ST_DONE]  <= sar.done;
                    wb_dat_o[ST_BUSY]  <= sar.busy;
                    wb_dat_o[ST_COMP]  <= comparator_result_input_i;
                    wb_dat_o[ST_PHASE] <= phase_reg;
                    wb_dat_o[ST_BLANK] <= blanking_hold_switch_o;
                    wb_dat_o[ST_DRV_A] <= chopper_drive_a_o;
                end
                RESULT_OFS: begin
                    wb_dat_o <= {{(32 - CODE_W){1'b0}}, sar.code};
                end
                default: begin
                    wb_dat_o <= '0;
                end
            endcase
        end
    end

    // Successive-approximation conversion
    assign sar.start  = start_reg;
    assign sar.comp   = comparator_result_input_i;
    assign dac_code_o = sar.code;

    sar_sequencer u_sar (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .sar       (sar.seq)
    );
endmodule : chop_meter_ctrl
`default_nettype wire

// *** logic/chop_pkg.sv ***
`default_nettype none
package chop_pkg;
    // Clock and chop timing
    localparam int CLK_HZ         = 125_000_000;
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int CHOP_HZ        = 925;
    localparam int HALF_CHOP_CYC  = CLK_HZ / (2 * CHOP_HZ);
    localparam int BLANK_NS       = 180_000;
    localparam int BLANK_CYC      = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SAMPLE_DLY_NS  = 200_000;
    localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SAMPLE_LEN_NS  = 250_000;
    localparam int SAMPLE_LEN_CYC = (SAMPLE_LEN_NS * 1000) / CLK_PERIOD_PS;
    localparam int DRV_LEAD_NS    = 5_000;
    localparam int DRV_LEAD_CYC   = (DRV_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DRV_LAG_NS     = 10_000;
    localparam int DRV_LAG_CYC    = (DRV_LAG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_NS      = 1_000;
    localparam int SETTLE_CYC     = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W        = 17;

    // Conversion
    localparam int CODE_W = 14;

    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;

    // Control fields
    localparam int RANGE_LSB = 0;
    localparam int RANGE_W   = 3;
    localparam int ZSEL_BIT  = 4;
    localparam int START_BIT = 8;
    localparam logic [2:0] RANGE_RST = 3'h5;

    // Status fields
    localparam int ST_DONE  = 0;
    localparam int ST_BUSY  = 1;
    localparam int ST_COMP  = 2;
    localparam int ST_PHASE = 3;
    localparam int ST_BLANK = 4;
    localparam int ST_DRV_A = 5;

    typedef enum logic [2:0] {
        RANGE_1 = 3'h1,
        RANGE_2 = 3'h2,
        RANGE_3 = 3'h3,
        RANGE_4 = 3'h4,
        RANGE_5 = 3'h5
    } range_t;
endpackage : chop_pkg
`default_nettype wire

// *** logic/pulse_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int CW    = 17,
    parameter int COUNT = 100
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic trig_i,
    output logic      active_o,
    output logic      done_o
);
    logic [CW-1:0] cnt_reg;

    // Active for COUNT cycles after a trigger, retriggerable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= '0;
            active_o <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (trig_i) begin
                cnt_reg  <= CW'(COUNT - 1);
                active_o <= 1'b1;
            end else if (active_o) begin
                if (cnt_reg == '0) begin
                    active_o <= 1'b0;
                    done_o   <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule : pulse_timer
`default_nettype wire

// *** logic/sar_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sar_if #(parameter int CODE_W = 14);
    logic              start;
    logic              comp;
    logic              busy;
    logic              done;
    logic [CODE_W-1:0] code;

    modport seq  (input start, input comp, output busy, output done, output code);
    modport ctrl (output start, output comp, input busy, input done, input code);
endinterface : sar_if
`default_nettype wire

// *** logic/sar_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer
    import chop_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    sar_if.seq        sar
);
    typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_DECIDE} sar_state_t;

    sar_state_t  state_reg;
    logic [3:0]  bit_reg;
    logic [7:0]  wait_reg;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= S_IDLE;
            bit_reg   <= '0;
            wait_reg  <= '0;
            sar.code  <= '0;
            sar.busy  <= 1'b0;
            sar.done  <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (sar.start) begin
                        sar.code             <= '0;
                        sar.code[CODE_W-1]   <= 1'b1;
                        bit_reg              <= 4'(CODE_W - 1);
                        wait_reg             <= 8'(SETTLE - 1);
                        sar.busy             <= 1'b1;
                        sar.done             <= 1'b0;
                        state_reg            <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (wait_reg == '0) begin
                        state_reg <= S_DECIDE;
                    end else begin
                        wait_reg <= wait_reg - 1'b1;
                    end
                end
                S_DECIDE: begin
                    if (!sar.comp) begin
                        sar.code[bit_reg] <= 1'b0;
                    end
                    if (bit_reg == '0) begin
                        sar.busy  <= 1'b0;
                        sar.done  <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        sar.code[bit_reg - 1'b1] <= 1'b1;
                        bit_reg                  <= bit_reg - 1'b1;
                        wait_reg                 <= 8'(SETTLE - 1);
                        state_reg                <= S_SETTLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule : sar_sequencer
`default_nettype wire

// *** sim/chain_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Comparator and analogue chain seen by the sequencer
module chain_model
    import chop_pkg::*;
#(
    parameter int LAG = 3
) (
    input  wire logic              clk_i,
    input  wire logic [CODE_W-1:0] dac_code_i,
    input  wire logic              zener_sel_i,
    input  wire logic [14:0]       det_lvl_i,
    input  wire logic [14:0]       zen_lvl_i,
    output logic                   comp_o
);
    logic [LAG-1:0] pipe_q;
    logic [14:0]    lvl;

    assign lvl = zener_sel_i ? zen_lvl_i : det_lvl_i;

    // Slow comparator: result lags the code by LAG cycles
    always_ff @(posedge clk_i) begin
        pipe_q <= {pipe_q[LAG-2:0], ({1'b0, dac_code_i} < lvl)};
    end

    assign comp_o = pipe_q[LAG-1];
endmodule : chain_model
`default_nettype wire

// *** sim/chop_meter_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module chop_meter_ctrl_chk
    import chop_pkg::*;
#(
    parameter int HALF_CYC   = 2000,
    parameter int BLANK_LEN  = 40,
    parameter int SAMPLE_DLY = 50,
    parameter int SAMPLE_LEN = 100
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic chopper_drive_a_o,
    input wire logic chopper_drive_b_o,
    input wire logic blanking_hold_switch_o,
    input wire logic detector_sample_switch_a_o,
    input wire logic detector_sample_switch_b_o,
    input wire logic first_atten_pass_switch_o,
    input wire logic first_atten_div100_switch_o,
    input wire logic second_atten_pass_switch_o,
    input wire logic second_atten_div10_switch_o,
    input wire logic second_atten_div100_switch_o
);
    logic       bl_q;
    logic       sp_q;
    logic       arm_q;
    logic [1:0] last_q;
    int         per_q;
    int         run_q;
    int         srun_q;
    wire        sp = detector_sample_switch_a_o | detector_sample_switch_b_o;

    // Run lengths and spacing of blanking and sample pulses
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bl_q   <= 1'b0;
            sp_q   <= 1'b0;
            arm_q  <= 1'b0;
            last_q <= 2'h0;
            per_q  <= 0;
            run_q  <= 0;
            srun_q <= 0;
        end else begin
            bl_q   <= blanking_hold_switch_o;
            sp_q   <= sp;
            run_q  <= blanking_hold_switch_o ? run_q + 1 : 0;
            srun_q <= sp ? srun_q + 1 : 0;
            if (chopper_drive_b_o)
                arm_q <= 1'b1;
            if (blanking_hold_switch_o && !bl_q)
                per_q <= 1;
            else if (per_q != 0)
                per_q <= per_q + 1;
            if (sp && !sp_q)
                last_q <= {detector_sample_switch_b_o, detector_sample_switch_a_o};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_samp_excl: assert property (!(detector_sample_switch_a_o && detector_sample_switch_b_o))
        else $error("both sample switches closed");
    a_samp_alt: assert property ((sp && !sp_q) |-> last_q != {detector_sample_switch_b_o,
        detector_sample_switch_a_o}) else $error("sample switch repeated");
    a_samp_len: assert property ((sp_q && !sp) |-> srun_q == SAMPLE_LEN)
        else $error("sample pulse width wrong");
    a_samp_delay: assert property ((sp && !sp_q) |-> per_q >= SAMPLE_DLY - 2 && per_q <= SAMPLE_DLY + 4)
        else $error("sample delay wrong");
    a_blank_len: assert property ((bl_q && !blanking_hold_switch_o) |-> run_q == BLANK_LEN)
        else $error("blanking width wrong");
    a_blank_period: assert property ((blanking_hold_switch_o && !bl_q && per_q != 0) |-> per_q == HALF_CYC)
        else $error("blanking spacing wrong");
    a_drive_lead: assert property ((arm_q && $rose(chopper_drive_a_o)) |-> chopper_drive_b_o [*8])
        else $error("drive a does not lead");
    a_drive_tail: assert property ($fell(chopper_drive_b_o) |-> chopper_drive_a_o [*8])
        else $error("drive a shorter than b");
    a_first_att: assert property (first_atten_pass_switch_o != first_atten_div100_switch_o)
        else $error("first attenuator not exclusive");
    a_second_att: assert property ($onehot({second_atten_pass_switch_o, second_atten_div10_switch_o,
        second_atten_div100_switch_o})) else $error("second attenuator not exclusive");
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus not acked");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_samp_a: cover property (detector_sample_switch_a_o && !sp_q);
    c_samp_b: cover property (detector_sample_switch_b_o && !sp_q);
    c_blank: cover property (blanking_hold_switch_o && !bl_q && per_q != 0);
endmodule : chop_meter_ctrl_chk

bind chop_meter_ctrl chop_meter_ctrl_chk #(
    .HALF_CYC(HALF_CYC), .BLANK_LEN(BLANK_LEN), .SAMPLE_DLY(SAMPLE_DLY), .SAMPLE_LEN(SAMPLE_LEN)
) chk_u (
    .clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .chopper_drive_a_o, .chopper_drive_b_o,
    .blanking_hold_switch_o, .detector_sample_switch_a_o, .detector_sample_switch_b_o,
    .first_atten_pass_switch_o, .first_atten_div100_switch_o, .second_atten_pass_switch_o,
    .second_atten_div10_switch_o, .second_atten_div100_switch_o
);
`default_nettype wire

// *** sim/tb_chop_meter_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_chop_meter_ctrl
    import chop_pkg::*;
;
    localparam int HC = 2000;
    logic              clk_i;
    logic              sys_rst_i;
    logic              wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]        wb_adr;
    logic [3:0]        wb_sel;
    logic [31:0]       wb_wdat, wb_rdat;
    logic              comp, drv_a, drv_b, blank, samp_a, samp_b, filt, zsel;
    logic [4:0]        att;
    logic [CODE_W-1:0] dac;
    logic [14:0]       det_lvl, zen_lvl;
    int                mismatches, n_compared, cyc_cnt;

    chop_meter_ctrl #(.HALF_CYC(HC), .BLANK_LEN(40), .SAMPLE_DLY(50), .SAMPLE_LEN(100)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .comparator_result_input_i(comp), .chopper_drive_a_o(drv_a), .chopper_drive_b_o(drv_b),
        .blanking_hold_switch_o(blank), .detector_sample_switch_a_o(samp_a),
        .detector_sample_switch_b_o(samp_b), .sample_filter_switch_o(filt),
        .first_atten_pass_switch_o(att[4]), .first_atten_div100_switch_o(att[3]),
        .second_atten_pass_switch_o(att[2]), .second_atten_div10_switch_o(att[1]),
        .second_atten_div100_switch_o(att[0]), .comparator_zener_select_o(zsel), .dac_code_o(dac)
    );

    chain_model model_u (
        .clk_i(clk_i), .dac_code_i(dac), .zener_sel_i(zsel), .det_lvl_i(det_lvl),
        .zen_lvl_i(zen_lvl), .comp_o(comp)
    );

    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;

    task end_sim;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        wb_sel  <= s;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb

    function automatic logic [5:0] sw_exp(input logic [2:0] r);
        case (r)
            3'h1: sw_exp = 6'b101001;
            3'h2: sw_exp = 6'b100100;
            3'h3: sw_exp = 6'b011000;
            3'h4: sw_exp = 6'b010100;
            default: sw_exp = 6'b010010;
        endcase
    endfunction : sw_exp

    task automatic t_reset;
        logic [31:0] q;
        wb(1'b0, CTRL_OFS, 32'h0, 4'hf, q);
        chk(q, 32'h5);
        chk({26'h0, att, filt}, {26'h0, sw_exp(3'h5)});
        chk({18'h0, dac}, 32'h0);
    endtask : t_reset

    task automatic t_ranges;
        logic [31:0] q;
        for (int r = 0; r < 8; r++) begin
            wb(1'b1, CTRL_OFS, 32'(r), 4'h1, q);
            repeat (2) @(posedge clk_i);
            chk({26'h0, att, filt}, {26'h0, sw_exp(r[2:0])});
        end
        // Range byte lane disabled: setting must not move
        wb(1'b1, CTRL_OFS, 32'h1, 4'h1, q);
        wb(1'b1, CTRL_OFS, 32'h2, 4'h2, q);
        repeat (2) @(posedge clk_i);
        chk({26'h0, att, filt}, {26'h0, sw_exp(3'h1)});
        wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
        chk(q, 32'h0);
    endtask : t_ranges

    task automatic t_conv(input logic zs, input logic [14:0] lvl);
        logic [31:0] q;
        logic [31:0] cmd;
        logic [13:0] e;
        int          n;
        int          t0;
        cmd = 32'h101 | {27'h0, zs, 4'h0};
        e = (lvl == 15'h0) ? 14'h0 : 14'(lvl - 15'h1);
        det_lvl <= zs ? ~lvl : lvl;
        zen_lvl <= zs ? lvl : ~lvl;
        wb(1'b1, CTRL_OFS, cmd, 4'h3, q);
        t0 = cyc_cnt;
        wb(1'b0, STATUS_OFS, 32'h0, 4'hf, q);
        chk({30'h0, q[ST_BUSY], q[ST_DONE]}, 32'h2);
        repeat (500) @(posedge clk_i);
        wb(1'b1, CTRL_OFS, cmd, 4'h3, q);
        n = 0;
        do begin
            wb(1'b0, STATUS_OFS, 32'h0, 4'hf, q);
            n++;
        end while (q[ST_DONE] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            mismatches++;
            end_sim();
        end
        chk({31'h0, (cyc_cnt - t0) <= 14 * (SETTLE_CYC + 1) + 12}, 32'h1);
        chk({31'h0, zsel}, {31'h0, zs});
        wb(1'b0, RESULT_OFS, 32'h0, 4'hf, q);
        chk(q, {18'h0, e});
        wb(1'b1, RESULT_OFS, 32'h1555, 4'hf, q);
        repeat (300) @(posedge clk_i);
        wb(1'b0, STATUS_OFS, 32'h0, 4'hf, q);
        chk({30'h0, q[ST_BUSY], q[ST_DONE]}, 32'h1);
        chk({31'h0, q[ST_COMP]}, {31'h0, lvl != 15'h0});
        wb(1'b0, RESULT_OFS, 32'h0, 4'hf, q);
        chk(q, {18'h0, e});
        chk({18'h0, dac}, {18'h0, e});
    endtask : t_conv

    task automatic t_phase;
        logic [31:0] q;
        int          n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while ((k == 0 ? samp_a : samp_b) !== 1'b1 && n < 3 * HC) begin
                @(posedge clk_i);
                n++;
            end
            chk({31'h0, n < 3 * HC}, 32'h1);
            wb(1'b0, STATUS_OFS, 32'h0, 4'hf, q);
            chk({31'h0, q[ST_PHASE]}, {31'h0, k == 0});
        end
    endtask : t_phase

    initial begin
        clk_i      = 1'b0;
        sys_rst_i  = 1'b1;
        wb_cyc     = 1'b0;
        wb_stb     = 1'b0;
        wb_we      = 1'b0;
        wb_adr     = 8'h0;
        wb_sel     = 4'h0;
        wb_wdat    = 32'h0;
        det_lvl    = 15'h0;
        zen_lvl    = 15'h0;
        mismatches = 0;
        n_compared = 0;
        cyc_cnt    = 0;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_ranges();
        t_conv(1'b0, 15'h0001);
        t_conv(1'b0, 15'h2aab);
        t_conv(1'b1, 15'h4000);
        t_conv(1'b1, 15'h0000);
        t_phase();
        end_sim();
    end
endmodule : tb_chop_meter_ctrl
`default_nettype wire
